// File: logic/tsh_pkg.sv
// constants and types for the sensor read and eeprom half select target
package tsh_pkg;
  // control bytes of the half select commands
  localparam logic [7:0] CTL_HS_LOW   = 8'h6C;
  localparam logic [7:0] CTL_HS_HIGH  = 8'h6E;
  localparam logic [7:0] CTL_HS_QUERY = 8'h6D;
  // bit of the control byte that carries the wanted half
  localparam int unsigned HS_BIT_POS  = 1;
  // array organisation
  localparam int unsigned ARRAY_BYTES    = 512;
  localparam int unsigned HALF_BYTES     = 256;
  localparam int unsigned QUAD_BYTES     = 128;
  localparam int unsigned PAGE_BYTES     = 16;
  localparam int unsigned PAGES_PER_QUAD = QUAD_BYTES / PAGE_BYTES;
  localparam int unsigned ARRAY_AW       = $clog2(ARRAY_BYTES);
  localparam int unsigned WORD_AW        = $clog2(HALF_BYTES);
  // values after reset
  localparam logic       HALF_RST = 1'b0;
  localparam logic [7:0] PTR_RST  = 8'h00;
  // bus bit levels and counts
  localparam logic       ACK_LVL    = 1'b0;
  localparam logic       RW_READ    = 1'b1;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] ACK_BITS   = 4'h1;
  localparam logic [7:0] DUMMY_BYTE = 8'hFF;
  localparam logic [1:0] HS_DUMMIES = 2'h2;
  localparam logic [1:0] QRY_LAST   = 2'h1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_ADDR = 7'b000_0010,
    ST_AACK = 7'b000_0100,
    ST_RX   = 7'b000_1000,
    ST_RACK = 7'b001_0000,
    ST_TX   = 7'b010_0000,
    ST_MACK = 7'b100_0000
  } tsh_state_e;

  typedef enum logic [1:0] {
    MD_SENSOR = 2'h0,
    MD_HSET   = 2'h1,
    MD_HQRY   = 2'h2
  } tsh_mode_e;
endpackage : tsh_pkg

// File: logic/tsh_sensor_eeprom_sel.sv
// two-wire target: sensor word reads, pointer load, eeprom half select

// Contract
// - Start plus read address: device acks, then sends register high byte.
// - Master acks high byte, device sends low byte; master nacks, then Stop.
// - Pointer holds its last value, so repeated reads return same register.
// - Write address plus pointer byte: device acks both and loads pointer.
// - After repeated Start and read address, register returned high byte first.
// - Store is two 256-byte halves of two 128-byte quadrants of 16-byte pages.
// - Half zero maps words to quadrants 0 and 1, half one to 2 and 3.
// - Control byte 6Ch or 6Eh is acked and sets lower or upper half.
// - Two don't-care bytes after half set are acked; master ends with Stop.
// - Control byte 6Dh acked when half is zero, nacked when half is one.
// - After half query the device sends two dummy bytes; master nacks both.
// - Half select is zero after power-up.
// - Software reset clears the half select to zero.
// - Pointer byte after write address is latched as register selector.
module tsh_sensor_eeprom_sel
  import tsh_pkg::*;
#(
  parameter logic [6:0] TS_ADDR = 7'h18
) (
  input  wire logic                CLK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  input  wire logic                SCL,
  input  wire logic                SDA_I,
  input  wire logic                SOFT_RST,
  input  wire logic [15:0]         REG_RDATA,
  input  wire logic [WORD_AW-1:0]  WORD_ADDR,
  output logic                     SDA_O,
  output logic                     SDA_OE,
  output logic [7:0]               POINTER,
  output logic                     HALF_SEL,
  output logic [ARRAY_AW-1:0]      ARRAY_ADDR,
  output logic [1:0]               QUADRANT
);

  function automatic logic [3:0] inc4(input logic [3:0] v);
    inc4 = v + 4'h1;
  endfunction

  function automatic logic [1:0] inc2_sat(input logic [1:0] v);
    inc2_sat = (v == 2'h3) ? v : v + 2'h1;
  endfunction

  // link domain: sda sampled on each scl rise, event carried by a toggle
  logic lk_bit_r;
  logic lk_tgl_r;

  always_ff @(posedge SCL or negedge RST_B) begin
    if (!RST_B) begin
      lk_bit_r <= 1'b0;
      lk_tgl_r <= 1'b0;
    end else begin
      lk_bit_r <= SDA_I;
      lk_tgl_r <= ~lk_tgl_r;
    end
  end

  // pins and toggle into the system clock, {scl, sda, toggle}
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      sync3_r <= 3'h7;
    end else if (CE) begin
      sync1_r <= {SCL, SDA_I, lk_tgl_r};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // sync reset of toggle history is harmless: a first false edge meets idle

  wire scl_now   = sync2_r[2];
  wire scl_was   = sync3_r[2];
  wire sda_now   = sync2_r[1];
  wire sda_was   = sync3_r[1];
  wire scl_fall  = scl_was & ~scl_now;
  wire start_ev  = scl_now & scl_was & sda_was & ~sda_now;
  wire stop_ev   = scl_now & scl_was & ~sda_was & sda_now;
  wire bit_ev    = sync2_r[0] ^ sync3_r[0];
  // lk_bit_r is steady for the whole scl high phase when bit_ev is seen
  wire bit_val   = lk_bit_r;

  // control state
  tsh_state_e   state_r,   state_nxt;
  tsh_mode_e    mode_r,    mode_nxt;
  logic [3:0]   cnt_r,     cnt_nxt;
  logic [7:0]   sh_r,      sh_nxt;
  logic [7:0]   tx_r,      tx_nxt;
  logic [1:0]   byte_r,    byte_nxt;
  logic         rw_r,      rw_nxt;
  logic         mack_r,    mack_nxt;
  logic         oe_r,      oe_nxt;
  logic [15:0]  word_r,    word_nxt;
  logic [7:0]   ptr_r,     ptr_nxt;
  logic         half_r,    half_nxt;

  // address byte decode
  wire is_hset   = (sh_r == CTL_HS_LOW) | (sh_r == CTL_HS_HIGH);
  wire is_hqry   = (sh_r == CTL_HS_QUERY);
  wire hit_ts    = (sh_r[7:1] == TS_ADDR) & ~is_hset & ~is_hqry;
  wire hit_any   = hit_ts | is_hset | is_hqry;
  wire qry_ack   = (half_r == 1'b0);
  wire addr_ack  = hit_ts | is_hset | (is_hqry & qry_ack);
  wire rd_dir    = (sh_r[0] == RW_READ);

  // byte_r counts bytes sent after the first: low byte follows an even count, high an odd
  wire [7:0] sens_byte = byte_r[0] ? word_r[15:8] : word_r[7:0];
  wire [7:0] first_tx  = (mode_r == MD_HQRY) ? DUMMY_BYTE : REG_RDATA[15:8];
  wire [7:0] next_tx   = (mode_r == MD_HQRY) ? DUMMY_BYTE : sens_byte;
  wire       more_tx   = (mode_r == MD_HQRY) ? (byte_r < QRY_LAST) : mack_r;
  wire       rx_ack    = (mode_r != MD_HSET) | (byte_r < HS_DUMMIES);

  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    byte_nxt  = byte_r;
    rw_nxt    = rw_r;
    mack_nxt  = mack_r;
    oe_nxt    = oe_r;
    word_nxt  = word_r;
    ptr_nxt   = ptr_r;
    half_nxt  = half_r;
    if (start_ev) begin
      // start and repeated start both reopen address reception
      state_nxt = ST_ADDR;
      cnt_nxt   = 4'h0;
      oe_nxt    = 1'b0;
    end else if (stop_ev) begin
      state_nxt = ST_IDLE;
      oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (bit_ev) begin
            sh_nxt  = {sh_r[6:0], bit_val};
            cnt_nxt = inc4(cnt_r);
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_nxt  = 4'h0;
            byte_nxt = 2'h0;
            rw_nxt   = rd_dir;
            oe_nxt   = addr_ack;
            if (is_hset) begin
              mode_nxt = MD_HSET;
              half_nxt = sh_r[HS_BIT_POS];
            end else if (is_hqry) begin
              mode_nxt = MD_HQRY;
            end else begin
              mode_nxt = MD_SENSOR;
            end
            state_nxt = hit_any ? ST_AACK : ST_IDLE;
          end
        end
        ST_AACK: begin
          if (bit_ev) begin
            cnt_nxt = ACK_BITS;
          end else if (scl_fall && cnt_r == ACK_BITS) begin
            cnt_nxt = 4'h0;
            if (rw_r == RW_READ) begin
              // query always goes on to its dummy bytes, even after a nack
              word_nxt  = REG_RDATA;
              tx_nxt    = {first_tx[6:0], 1'b1};
              oe_nxt    = ~first_tx[7];
              cnt_nxt   = 4'h1;
              state_nxt = ST_TX;
            end else begin
              oe_nxt    = 1'b0;
              state_nxt = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (bit_ev) begin
            sh_nxt  = {sh_r[6:0], bit_val};
            cnt_nxt = inc4(cnt_r);
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_nxt   = 4'h0;
            oe_nxt    = rx_ack;
            byte_nxt  = inc2_sat(byte_r);
            state_nxt = ST_RACK;
            if (mode_r == MD_SENSOR && byte_r == 2'h0) begin
              ptr_nxt = sh_r;
            end
          end
        end
        ST_RACK: begin
          if (bit_ev) begin
            cnt_nxt = ACK_BITS;
          end else if (scl_fall && cnt_r == ACK_BITS) begin
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            state_nxt = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              oe_nxt    = 1'b0;
              cnt_nxt   = 4'h0;
              state_nxt = ST_MACK;
            end else begin
              oe_nxt  = ~tx_r[7];
              tx_nxt  = {tx_r[6:0], 1'b1};
              cnt_nxt = inc4(cnt_r);
            end
          end
        end
        ST_MACK: begin
          if (bit_ev) begin
            mack_nxt = (bit_val == ACK_LVL);
            cnt_nxt  = ACK_BITS;
          end else if (scl_fall && cnt_r == ACK_BITS) begin
            cnt_nxt = 4'h0;
            if (more_tx) begin
              byte_nxt  = byte_r + 2'h1;
              tx_nxt    = {next_tx[6:0], 1'b1};
              oe_nxt    = ~next_tx[7];
              cnt_nxt   = 4'h1;
              state_nxt = ST_TX;
            end else begin
              // a sensor nack or the second query dummy ends the read; the master closes with Stop
              oe_nxt    = 1'b0;
              state_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          oe_nxt    = 1'b0;
          state_nxt = ST_IDLE;
        end
      endcase
    end
    if (SOFT_RST) begin
      half_nxt = HALF_RST;
    end
  end

  // byte_r wraps during reads, so an acked low byte restarts with the high byte

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ST_IDLE;
      mode_r  <= MD_SENSOR;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      tx_r    <= 8'hFF;
      byte_r  <= 2'h0;
      rw_r    <= 1'b0;
      mack_r  <= 1'b0;
      oe_r    <= 1'b0;
    end else if (CE) begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      byte_r  <= byte_nxt;
      rw_r    <= rw_nxt;
      mack_r  <= mack_nxt;
      oe_r    <= oe_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      word_r <= 16'h0000;
      ptr_r  <= PTR_RST;
      half_r <= HALF_RST;
    end else if (CE) begin
      word_r <= word_nxt;
      ptr_r  <= ptr_nxt;
      half_r <= half_nxt;
    end
  end

  // array address and quadrant of the current word address
  wire [ARRAY_AW-1:0] arr_addr = {half_r, WORD_ADDR};
  wire [1:0]          quad     = {half_r, WORD_ADDR[WORD_AW-1]};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SDA_O      <= 1'b0;
      SDA_OE     <= 1'b0;
      POINTER    <= PTR_RST;
      HALF_SEL   <= HALF_RST;
      ARRAY_ADDR <= '0;
      QUADRANT   <= 2'h0;
    end else if (CE) begin
      SDA_O      <= 1'b0;
      SDA_OE     <= oe_nxt;
      POINTER    <= ptr_nxt;
      HALF_SEL   <= half_nxt;
      ARRAY_ADDR <= arr_addr;
      QUADRANT   <= quad;
    end
  end

endmodule // tsh_sensor_eeprom_sel

// File: tb/tsh_chk.sv
// port assertions for the two-wire target, bound to its top module
module tsh_chk
  import tsh_pkg::*;
(
  input wire logic                CLK,
  input wire logic                RST_B,
  input wire logic                CE,
  input wire logic                SCL,
  input wire logic                SOFT_RST,
  input wire logic [WORD_AW-1:0]  WORD_ADDR,
  input wire logic                SDA_O,
  input wire logic                SDA_OE,
  input wire logic [7:0]          POINTER,
  input wire logic                HALF_SEL,
  input wire logic [ARRAY_AW-1:0] ARRAY_ADDR,
  input wire logic [1:0]          QUADRANT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // scl seen high on two edges running
  sequence s_scl_high;
    SCL ##1 SCL;
  endsequence
  a_sda_drain: assert property (SDA_O == 1'b0)
    else $error("sda out high");
  a_oe_steady: assert property (s_scl_high |-> $stable(SDA_OE))
    else $error("sda enable moved, scl high");
  a_ptr_ack: assert property ($changed(POINTER) |-> ##[0:2] SDA_OE)
    else $error("pointer load without ack");
  a_half_ack: assert property ($changed(HALF_SEL) && !$past(SOFT_RST) |-> ##[0:2] SDA_OE)
    else $error("half moved without ack");
  a_soft_clear: assert property (CE && SOFT_RST |=> !HALF_SEL)
    else $error("soft reset left half set");
  a_frozen_state: assert property (!CE |=> $stable(POINTER) && $stable(HALF_SEL))
    else $error("state moved, enable low");
  a_array_addr: assert property (CE |=> ARRAY_ADDR == {$past(HALF_SEL), $past(WORD_ADDR)})
    else $error("array address wrong");
  a_quad_map: assert property (CE |=> QUADRANT == {$past(HALF_SEL), $past(WORD_ADDR[7])})
    else $error("quadrant wrong");
endmodule // tsh_chk

bind tsh_sensor_eeprom_sel tsh_chk tsh_chk_i (
  .CLK(CLK), .RST_B(RST_B), .CE(CE), .SCL(SCL), .SOFT_RST(SOFT_RST), .WORD_ADDR(WORD_ADDR),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .POINTER(POINTER), .HALF_SEL(HALF_SEL),
  .ARRAY_ADDR(ARRAY_ADDR), .QUADRANT(QUADRANT));

// File: tb/tsh_mst.sv
// two-wire bus master model on a link clock of its own
module tsh_mst (
  output logic      scl = 1'b1,
  output logic      sda_pull = 1'b0,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  int   q = 16;
  logic lclk = 1'b0;
  initial forever #6 lclk = ~lclk;
  // a quarter bit: wait, then set scl and the pull on sda
  task automatic ph(input logic c, input logic p);
    repeat (q) @(posedge lclk);
    scl <= c;
    sda_pull <= p;
  endtask
  task automatic start();
    ph(scl, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // data set in the low half, sampled in mid high
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, ~b);
    ph(1'b1, ~b);
    ph(1'b1, ~b);
    r = sda;
    ph(1'b0, ~b);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ai, a);
  endtask
endmodule // tsh_mst

// File: tb/tb_top.sv
// self-checking bench for the two-wire target
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_top
  import tsh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] TA = 7'h18; // arbitrary target address
  logic        clk = 1'b0, rst_b, ce = 1'b1, srst = 1'b0, scl, pull;
  logic [15:0] rdata = 16'h0000;
  logic [7:0]  wa = 8'h00;
  logic [15:0] regs [256];
  wire         sda_o, sda_oe, half;
  wire  [7:0]  ptr;
  wire  [8:0]  aa;
  wire  [1:0]  quad;
  wire         sda = ~(pull | sda_oe);
  int          err_count = 0, checks_done = 0, seed = 91, cyc = 0, mh = 0, mp = 0;
  initial forever #25 clk = ~clk;
  tsh_sensor_eeprom_sel #(.TS_ADDR(TA)) tsh_sensor_eeprom_sel_i (.CLK(clk), .RST_B(rst_b),
    .CE(ce), .SCL(scl), .SDA_I(sda), .SOFT_RST(srst), .REG_RDATA(rdata), .WORD_ADDR(wa),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .POINTER(ptr), .HALF_SEL(half), .ARRAY_ADDR(aa),
    .QUADRANT(quad));
  tsh_mst tsh_mst_i (.scl(scl), .sda_pull(pull), .sda(sda));
  // sensor register file seen through the pointer
  always @(posedge clk) rdata <= regs[ptr];
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  task automatic wr(input logic [7:0] d, input logic ea);
    logic [7:0] r;
    logic       a;
    tsh_mst_i.xfer(d, 1'b1, r, a);
    `CHK("ack", ea, a)
  endtask
  task automatic rd(input logic [7:0] e, input logic ma);
    logic [7:0] r;
    logic       a;
    tsh_mst_i.xfer(8'hFF, ma, r, a);
    `CHK("byte", e, r)
  endtask
  initial begin
    logic [7:0] p;
    // a real falling edge, so the scl-side flops see their reset as well
    rst_b <= 1'b0;
    for (int i = 0; i < 256; i++) regs[i] = 16'($random(seed));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("half", HALF_RST, half)
    `CHK("ptr", PTR_RST, ptr)
    for (int i = 0; i < 3; i++) begin
      p = 8'($random(seed));
      tsh_mst_i.q = (i == 2) ? 24 : 16;
      tsh_mst_i.start();
      wr({TA, 1'b0}, ACK_LVL);
      wr(p, ACK_LVL);
      mp = p;
      tsh_mst_i.start();
      for (int k = 0; k < 2; k++) begin
        if (k == 1) tsh_mst_i.start();
        wr({TA, RW_READ}, ACK_LVL);
        rd(regs[mp][15:8], 1'b0);
        rd(regs[mp][7:0], 1'b1);
        tsh_mst_i.stop();
      end
      `CHK("ptr", mp, ptr)
      $display("test pointer read %0d end", i);
    end
    tsh_mst_i.start();
    wr({TA ^ 7'h01, RW_READ}, ~ACK_LVL);
    tsh_mst_i.stop();
    $display("test unknown address end");
    for (int i = 0; i < 3; i++) begin
      p = i[0] ? CTL_HS_LOW : CTL_HS_HIGH;
      tsh_mst_i.start();
      wr(p, ACK_LVL);
      repeat (2) wr(8'($random(seed)), ACK_LVL);
      tsh_mst_i.stop();
      mh = p[HS_BIT_POS];
      `CHK("half", mh, half)
      tsh_mst_i.start();
      wr(CTL_HS_QUERY, (mh == 1) ? ~ACK_LVL : ACK_LVL);
      repeat (2) rd(DUMMY_BYTE, 1'b1);
      tsh_mst_i.stop();
      @(posedge clk) wa <= 8'($random(seed));
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("array", mh * HALF_BYTES + wa, aa)
      `CHK("quad", (mh * HALF_BYTES + wa) / QUAD_BYTES, quad)
      $display("test half select %0d end", i);
    end
    @(posedge clk);
    ce <= 1'b0;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("frozen", 1'b1, half)
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    @(negedge clk);
    `CHK("half", HALF_RST, half)
    tsh_mst_i.start();
    wr(CTL_HS_QUERY, ACK_LVL);
    repeat (2) rd(DUMMY_BYTE, 1'b1);
    tsh_mst_i.stop();
    $display("test soft reset end");
    summarize();
  end
endmodule // tb_top
